// file: hw/evstream_pkg.sv
// Purpose: Shared constants and 8b/10b encoder for the event stream
// Assumes: Characters are {abcdei,fghj}, bit 9 (a) sent first
// Notes: Only K28.0, K28.1 and K28.5 are needed as control characters
package evstream_pkg;
    localparam int CODE_W = 8;
    localparam int CHAR_W = 10;
    localparam logic [7:0] EV_NULL = 8'h00;
    localparam logic [7:0] EV_SEC0 = 8'h70;
    localparam logic [7:0] EV_SEC1 = 8'h71;
    localparam logic [7:0] EV_LOG_STOP = 8'h79;
    localparam logic [7:0] EV_BEACON = 8'h7a;
    localparam logic [7:0] EV_PRESC_SYNC = 8'h7b;
    localparam logic [7:0] EV_TS_INC = 8'h7c;
    localparam logic [7:0] EV_TS_RST = 8'h7d;
    localparam logic [7:0] EV_SEQ_END = 8'h7f;
    localparam logic [7:0] K_START = 8'h1c;
    localparam logic [7:0] K_END = 8'h3c;
    localparam logic [7:0] K_COMMA = 8'hbc;
    localparam logic [1:0] COMMA_CYCLE = 2'h0;
    localparam logic [15:0] CSUM_INIT = 16'hffff;
    localparam int FIFO_DEPTH = 8;
    localparam int DLY_DEPTH = 16;
    localparam int HB_TIMEOUT = 100000;

    // Returns {running disparity out, character}; rd 1 means RD+
    function automatic logic [10:0] enc8b10b(input logic k, input logic [7:0] b,
                                             input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic rdx;
        logic rdm;
        logic [9:0] c;
        rdx = k ? 1'b0 : rd;
        case (b[4:0])
            5'd0: s6 = 6'b100111;  5'd1: s6 = 6'b011101;  5'd2: s6 = 6'b101101;
            5'd3: s6 = 6'b110001;  5'd4: s6 = 6'b110101;  5'd5: s6 = 6'b101001;
            5'd6: s6 = 6'b011001;  5'd7: s6 = 6'b111000;  5'd8: s6 = 6'b111001;
            5'd9: s6 = 6'b100101;  5'd10: s6 = 6'b010101; 5'd11: s6 = 6'b110100;
            5'd12: s6 = 6'b001101; 5'd13: s6 = 6'b101100; 5'd14: s6 = 6'b011100;
            5'd15: s6 = 6'b010111; 5'd16: s6 = 6'b011011; 5'd17: s6 = 6'b100011;
            5'd18: s6 = 6'b010011; 5'd19: s6 = 6'b110010; 5'd20: s6 = 6'b001011;
            5'd21: s6 = 6'b101010; 5'd22: s6 = 6'b011010; 5'd23: s6 = 6'b111010;
            5'd24: s6 = 6'b110011; 5'd25: s6 = 6'b100110; 5'd26: s6 = 6'b010110;
            5'd27: s6 = 6'b110110; 5'd28: s6 = 6'b001110; 5'd29: s6 = 6'b101110;
            5'd30: s6 = 6'b011110; default: s6 = 6'b101011;
        endcase
        if (k) begin
            s6 = 6'b001111;
        end else if (rdx && ($countones(s6) != 3 || b[4:0] == 5'd7)) begin
            s6 = ~s6;
        end
        rdm = ($countones(s6) == 3) ? rdx : ($countones(s6) > 3);
        case (b[7:5])
            3'd0: s4 = 4'b1011;  3'd1: s4 = 4'b1001;  3'd2: s4 = 4'b0101;
            3'd3: s4 = 4'b1100;  3'd4: s4 = 4'b1101;  3'd5: s4 = 4'b1010;
            3'd6: s4 = 4'b0110;  default: s4 = 4'b1110;
        endcase
        // Alternate D.x.7 avoids a run of five equal bits
        if (b[7:5] == 3'd7 && !k && ((!rdm && (b[4:0] == 5'd17 || b[4:0] == 5'd18 ||
            b[4:0] == 5'd20)) || (rdm && (b[4:0] == 5'd11 || b[4:0] == 5'd13 ||
            b[4:0] == 5'd14)))) begin
            s4 = 4'b0111;
        end
        if (rdm && ($countones(s4) != 2 || b[7:5] == 3'd3)) begin
            s4 = ~s4;
        end
        c = {s6, s4};
        if (k && rd) begin
            c = ~c;
        end
        enc8b10b = {(($countones(c) == 5) ? rd : ($countones(c) > 5)), c};
    endfunction : enc8b10b
endpackage : evstream_pkg

// file: hw/evstream_if.sv
// Purpose: Link carrying two encoded characters per event clock cycle
// Assumes: Both ends share clk_i
// Notes: The testbench joins the two ends through this interface
`timescale 1ns/1ns
interface evstream_if;
    logic [9:0] ev_char;
    logic [9:0] dat_char;
    modport tx (output ev_char, output dat_char);
    modport rx (input ev_char, input dat_char);
endinterface : evstream_if

// file: hw/timing_event_stream_framer.sv
// Purpose: Event stream framer of the event master, plus its byte FIFO
// Assumes: Sources and buffer writer run on clk_i, one frame per cycle
// Notes: Buffer bytes are pushed most significant byte of each word first
`timescale 1ns/1ns
module stream_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic s_valid_i,
    output logic s_ready_o,
    input wire logic [WIDTH-1:0] s_data_i,
    output logic m_valid_o,
    input wire logic m_ready_i,
    output logic [WIDTH-1:0] m_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign s_ready_o = (cnt_reg != (AW+1)'(DEPTH));
    assign m_valid_o = (cnt_reg != '0);
    assign m_data_o = mem[rp_reg];
    assign push = s_valid_i && s_ready_o;
    assign pop = m_valid_o && m_ready_i;

    always_comb begin
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
        end
        if (pop) begin
            rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; occupancy alone says what is valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_reg] <= s_data_i;
        end
    end
endmodule : stream_fifo

// How it works
// RL1: two encoded characters every cycle, no gaps
// RL2: one event per frame, else null code
// RL3: comma replaces null on every fourth cycle
// RL4: pending event overrides a scheduled comma
// RL5: events as data characters; D00.0 means none
// RL6: event codes are eight bits wide
// RL7: receiver shifts seconds bits on 0x70/0x71
// RL8: receiver stops event log on 0x79
// RL9: master sends 0x7A beacon; receiver resets heartbeat
// RL10: sources never use the beacon code
// RL11: 0x7B-0x7D act at receiver; 0x7F never sent
// RL12: event first; even dbus, odd buffer slot
// RL13: idle buffer slots carry D00.0
// RL14: transfer opens K28.0, closes K28.1
// RL15: segment address follows the start character
// RL16: payload bytes in order, MSB first
// RL17: checksum 0xFFFF minus all, high byte first
// RL18: receiver aligns on the periodic comma
// RL19: receiver delay FIFO tops up to target
// RL20: eight dbus bits sent every other cycle
// RL21: priority encoder picks one event code
// RL22: one running disparity across both characters
module timing_event_stream_framer #(
    parameter int N_SRC = 4,
    parameter int BUF_DEPTH = evstream_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic beacon_req_i,
    output logic beacon_ack_o,
    input wire logic [N_SRC-1:0] src_req_i,
    input wire logic [N_SRC-1:0][7:0] src_code_i,
    output logic [N_SRC-1:0] src_ack_o,
    input wire logic [7:0] dbus_i,
    input wire logic [7:0] seg_addr_i,
    input wire logic buf_valid_i,
    output logic buf_ready_o,
    input wire logic [7:0] buf_data_i,
    input wire logic buf_last_i,
    output logic buf_busy_o,
    evstream_if.tx link
);
    typedef enum logic [2:0] {
        BUF_IDLE = 3'b000,
        BUF_SEG = 3'b001,
        BUF_DATA = 3'b010,
        BUF_END = 3'b011,
        BUF_CSH = 3'b100,
        BUF_CSL = 3'b101
    } buf_state_t;

    buf_state_t st_reg, st_next;
    logic [1:0] cyc_reg, cyc_next;
    logic rd_reg, rd_next;
    logic [9:0] ev_reg, ev_next, dat_reg, dat_next;
    logic [15:0] csum_reg, csum_next;
    logic [7:0] seg_reg, seg_next;
    logic [3:0] pkts_reg, pkts_next;
    logic f_valid, f_ready, f_last;
    logic [7:0] f_data;
    logic [10:0] e1, e2;
    logic ev_k, dat_k;
    logic [7:0] ev_byte, dat_byte;
    logic have_ev;
    logic [7:0] pick_code;
    logic push_last, pop_last;

    stream_fifo #(.WIDTH(9), .DEPTH(BUF_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .s_valid_i(buf_valid_i),
        .s_ready_o(buf_ready_o),
        .s_data_i({buf_last_i, buf_data_i}),
        .m_valid_o(f_valid),
        .m_ready_i(f_ready),
        .m_data_o({f_last, f_data})
    );

    assign push_last = buf_valid_i && buf_ready_o && buf_last_i;
    assign pop_last = f_valid && f_ready && f_last;
    assign buf_busy_o = (st_reg != BUF_IDLE);

    // Beacon wins, then the lowest source index
    always_comb begin
        have_ev = 1'b0;
        pick_code = evstream_pkg::EV_NULL;
        beacon_ack_o = 1'b0;
        src_ack_o = '0;
        if (beacon_req_i) begin
            have_ev = 1'b1; // RL9
            pick_code = evstream_pkg::EV_BEACON;
            beacon_ack_o = 1'b1;
        end else begin
            for (int i = N_SRC - 1; i >= 0; i--) begin
                if (src_req_i[i]) begin
                    src_ack_o = '0;
                    src_ack_o[i] = 1'b1; // RL21
                    pick_code = src_code_i[i]; // RL6
                    // Null and end-of-sequence are taken but never sent
                    have_ev = (src_code_i[i] != evstream_pkg::EV_NULL) &&
                              (src_code_i[i] != evstream_pkg::EV_SEQ_END); // RL11
                end
            end
        end
    end

    always_comb begin
        st_next = st_reg;
        csum_next = csum_reg;
        seg_next = seg_reg;
        f_ready = 1'b0;
        cyc_next = cyc_reg + 2'h1; // RL1
        ev_k = 1'b0;
        ev_byte = evstream_pkg::EV_NULL; // RL2
        if (have_ev) begin
            ev_byte = pick_code; // RL4 RL5
        end else if (cyc_reg == evstream_pkg::COMMA_CYCLE) begin
            ev_k = 1'b1; // RL3
            ev_byte = evstream_pkg::K_COMMA;
        end
        dat_k = 1'b0;
        dat_byte = evstream_pkg::EV_NULL; // RL13
        if (!cyc_reg[0]) begin
            dat_byte = dbus_i; // RL12 RL20
        end else begin
            case (st_reg)
                BUF_IDLE: begin
                    // Wait for a whole packet, or a full FIFO for long ones
                    if (pkts_reg != 4'h0 || (f_valid && !buf_ready_o)) begin
                        dat_k = 1'b1; // RL14
                        dat_byte = evstream_pkg::K_START;
                        seg_next = seg_addr_i;
                        st_next = BUF_SEG;
                    end
                end
                BUF_SEG: begin
                    dat_byte = seg_reg; // RL15
                    csum_next = evstream_pkg::CSUM_INIT - {8'h00, seg_reg}; // RL17
                    st_next = BUF_DATA;
                end
                BUF_DATA: begin
                    // Underrun sends a zero byte; the checksum still holds
                    dat_byte = f_valid ? f_data : 8'h00; // RL16
                    f_ready = 1'b1;
                    csum_next = csum_reg - {8'h00, dat_byte}; // RL17
                    if (f_valid && f_last) begin
                        st_next = BUF_END;
                    end
                end
                BUF_END: begin
                    dat_k = 1'b1; // RL14
                    dat_byte = evstream_pkg::K_END;
                    st_next = BUF_CSH;
                end
                BUF_CSH: begin
                    dat_byte = csum_reg[15:8]; // RL17
                    st_next = BUF_CSL;
                end
                BUF_CSL: begin
                    dat_byte = csum_reg[7:0]; // RL17
                    st_next = BUF_IDLE;
                end
                default: begin
                    st_next = BUF_IDLE;
                end
            endcase
        end
        e1 = evstream_pkg::enc8b10b(ev_k, ev_byte, rd_reg); // RL22
        e2 = evstream_pkg::enc8b10b(dat_k, dat_byte, e1[10]); // RL22
        ev_next = e1[9:0];
        dat_next = e2[9:0];
        rd_next = e2[10];
        pkts_next = pkts_reg + {3'h0, push_last} - {3'h0, pop_last};
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= BUF_IDLE;
            cyc_reg <= 2'h0;
            rd_reg <= 1'b0;
            ev_reg <= 10'h000;
            dat_reg <= 10'h000;
            csum_reg <= 16'h0000;
            seg_reg <= 8'h00;
            pkts_reg <= 4'h0;
        end else begin
            st_reg <= st_next;
            cyc_reg <= cyc_next;
            rd_reg <= rd_next;
            ev_reg <= ev_next;
            dat_reg <= dat_next;
            csum_reg <= csum_next;
            seg_reg <= seg_next;
            pkts_reg <= pkts_next;
        end
    end

    assign link.ev_char = ev_reg;
    assign link.dat_char = dat_reg;
endmodule : timing_event_stream_framer

// file: hw/timing_event_stream_receiver.sv
// Purpose: Event receiver end: decode, align, act on special codes
// Assumes: Link characters come from logic on clk_i
// Notes: Decoding ignores disparity errors; unknown characters read as null
`timescale 1ns/1ns
module timing_event_stream_receiver #(
    parameter int HB_LIMIT = evstream_pkg::HB_TIMEOUT,
    parameter int DLY_N = evstream_pkg::DLY_DEPTH
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    evstream_if.rx link,
    input wire logic [3:0] meas_delay_i,
    input wire logic [3:0] target_delay_i,
    input wire logic log_restart_i,
    output logic locked_o,
    output logic event_valid_o,
    output logic [7:0] event_code_o,
    output logic beacon_o,
    output logic presc_sync_o,
    output logic log_stop_o,
    output logic hb_timeout_o,
    output logic [31:0] ts_count_o,
    output logic [31:0] seconds_o,
    output logic [7:0] dbus_o,
    output logic buf_byte_valid_o,
    output logic [7:0] buf_byte_o,
    output logic [7:0] buf_seg_o,
    output logic buf_done_o,
    output logic buf_csum_ok_o
);
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_SEG = 3'b001,
        RX_DATA = 3'b010,
        RX_CSH = 3'b011,
        RX_CSL = 3'b100
    } rx_state_t;

    // Returns {known, k, byte} by trying every data character and the three control characters
    function automatic logic [9:0] dec(input logic [9:0] c);
        logic [10:0] e;
        dec = 10'h000;
        for (int i = 0; i < 256; i++) begin
            for (int r = 0; r < 2; r++) begin
                e = evstream_pkg::enc8b10b(1'b0, 8'(i), r[0]);
                if (e[9:0] == c) begin
                    dec = {2'b10, 8'(i)};
                end
            end
        end
        for (int r = 0; r < 2; r++) begin
            if (evstream_pkg::enc8b10b(1'b1, evstream_pkg::K_COMMA, r[0]) == {1'b0, c} ||
                evstream_pkg::enc8b10b(1'b1, evstream_pkg::K_COMMA, r[0]) == {1'b1, c}) begin
                dec = {2'b11, evstream_pkg::K_COMMA};
            end
            if (evstream_pkg::enc8b10b(1'b1, evstream_pkg::K_START, r[0]) ==
                {r[0], c} ||
                evstream_pkg::enc8b10b(1'b1, evstream_pkg::K_START, r[0]) ==
                {~r[0], c}) begin
                dec = {2'b11, evstream_pkg::K_START};
            end
            if (evstream_pkg::enc8b10b(1'b1, evstream_pkg::K_END, r[0]) == {1'b0, c} ||
                evstream_pkg::enc8b10b(1'b1, evstream_pkg::K_END, r[0]) == {1'b1, c}) begin
                dec = {2'b11, evstream_pkg::K_END};
            end
        end
    endfunction : dec

    localparam int AW = $clog2(DLY_N);
    logic [8:0] dmem [DLY_N];
    logic [AW-1:0] wp_reg;
    logic [9:0] de, dd;
    logic comma, even, ev_ok;
    logic [3:0] dly;
    logic [8:0] ev_d;
    logic phase_reg, phase_next, lock_reg, lock_next;
    rx_state_t st_reg, st_next;
    logic [15:0] csum_reg, csum_next;
    logic [7:0] hi_reg, hi_next, seg_reg, seg_next, byte_reg, byte_next;
    logic bv_reg, bv_next, done_reg, done_next, ok_reg, ok_next;
    logic [7:0] dbus_reg, dbus_next, code_reg, code_next;
    logic evv_reg, evv_next, bcn_reg, bcn_next, ps_reg, ps_next, stop_reg, stop_next;
    logic [31:0] ts_reg, ts_next, sh_reg, sh_next, sec_reg, sec_next;
    logic [31:0] hb_reg, hb_next;

    assign de = dec(link.ev_char);
    assign dd = dec(link.dat_char);
    assign comma = de[9] && de[8] && (de[7:0] == evstream_pkg::K_COMMA);
    // Comma only lands on even cycles, so it fixes the slot phase
    assign even = comma || !phase_reg; // RL18
    assign ev_ok = de[9] && !de[8] && (de[7:0] != evstream_pkg::EV_NULL); // RL5
    assign dly = (target_delay_i > meas_delay_i) ? target_delay_i - meas_delay_i : 4'h0;
    // Delay line brings total latency up to the target
    assign ev_d = (dly == 4'h0) ? {ev_ok, de[7:0]} : dmem[wp_reg - AW'(dly)]; // RL19

    always_ff @(posedge clk_i) begin
        dmem[wp_reg] <= {ev_ok, de[7:0]};
    end

    always_comb begin
        phase_next = even;
        lock_next = lock_reg || comma; // RL18
        st_next = st_reg;
        csum_next = csum_reg;
        hi_next = hi_reg;
        seg_next = seg_reg;
        byte_next = byte_reg;
        bv_next = 1'b0;
        done_next = 1'b0;
        ok_next = ok_reg;
        dbus_next = dbus_reg;
        if (lock_reg || comma) begin
            if (even) begin
                dbus_next = dd[7:0]; // RL12 RL20
            end else if (dd[9] && dd[8] && dd[7:0] == evstream_pkg::K_START) begin
                st_next = RX_SEG; // RL14
            end else begin
                case (st_reg)
                    RX_SEG: begin
                        seg_next = dd[7:0]; // RL15
                        csum_next = evstream_pkg::CSUM_INIT - {8'h00, dd[7:0]};
                        st_next = RX_DATA;
                    end
                    RX_DATA: begin
                        if (dd[8]) begin
                            st_next = RX_CSH; // RL14
                        end else begin
                            byte_next = dd[7:0]; // RL16
                            bv_next = 1'b1;
                            csum_next = csum_reg - {8'h00, dd[7:0]};
                        end
                    end
                    RX_CSH: begin
                        hi_next = dd[7:0];
                        st_next = RX_CSL;
                    end
                    RX_CSL: begin
                        ok_next = ({hi_reg, dd[7:0]} == csum_reg); // RL17
                        done_next = 1'b1;
                        st_next = RX_IDLE;
                    end
                    default: begin
                        st_next = RX_IDLE;
                    end
                endcase
            end
        end
        evv_next = ev_d[8];
        code_next = ev_d[7:0];
        bcn_next = ev_d[8] && ev_d[7:0] == evstream_pkg::EV_BEACON; // RL9
        ps_next = ev_d[8] && ev_d[7:0] == evstream_pkg::EV_PRESC_SYNC; // RL11
        // Stop request wins over a restart in the same cycle
        stop_next = (stop_reg && !log_restart_i) ||
                    (ev_d[8] && ev_d[7:0] == evstream_pkg::EV_LOG_STOP); // RL8
        sh_next = sh_reg;
        ts_next = ts_reg;
        sec_next = sec_reg;
        if (ev_d[8] && (ev_d[7:0] == evstream_pkg::EV_SEC0 ||
                        ev_d[7:0] == evstream_pkg::EV_SEC1)) begin
            sh_next = {sh_reg[30:0], ev_d[0]}; // RL7
        end
        if (ev_d[8] && ev_d[7:0] == evstream_pkg::EV_TS_INC) begin
            ts_next = ts_reg + 32'h1; // RL11
        end
        if (ev_d[8] && ev_d[7:0] == evstream_pkg::EV_TS_RST) begin
            ts_next = 32'h0; // RL11
            sec_next = sh_reg;
        end
        hb_next = bcn_next ? 32'h0 : // RL9
                  (hb_reg == 32'(HB_LIMIT)) ? hb_reg : hb_reg + 32'h1;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_reg <= '0;
            phase_reg <= 1'b0;
            lock_reg <= 1'b0;
            st_reg <= RX_IDLE;
            csum_reg <= 16'h0000;
            hi_reg <= 8'h00;
            seg_reg <= 8'h00;
            byte_reg <= 8'h00;
            bv_reg <= 1'b0;
            done_reg <= 1'b0;
            ok_reg <= 1'b0;
            dbus_reg <= 8'h00;
            evv_reg <= 1'b0;
            code_reg <= 8'h00;
            bcn_reg <= 1'b0;
            ps_reg <= 1'b0;
            stop_reg <= 1'b0;
            sh_reg <= 32'h0;
            ts_reg <= 32'h0;
            sec_reg <= 32'h0;
            hb_reg <= 32'h0;
        end else begin
            wp_reg <= wp_reg + 1'b1;
            phase_reg <= phase_next;
            lock_reg <= lock_next;
            st_reg <= st_next;
            csum_reg <= csum_next;
            hi_reg <= hi_next;
            seg_reg <= seg_next;
            byte_reg <= byte_next;
            bv_reg <= bv_next;
            done_reg <= done_next;
            ok_reg <= ok_next;
            dbus_reg <= dbus_next;
            evv_reg <= evv_next;
            code_reg <= code_next;
            bcn_reg <= bcn_next;
            ps_reg <= ps_next;
            stop_reg <= stop_next;
            sh_reg <= sh_next;
            ts_reg <= ts_next;
            sec_reg <= sec_next;
            hb_reg <= hb_next;
        end
    end

    assign locked_o = lock_reg;
    assign event_valid_o = evv_reg;
    assign event_code_o = code_reg;
    assign beacon_o = bcn_reg;
    assign presc_sync_o = ps_reg;
    assign log_stop_o = stop_reg;
    assign hb_timeout_o = (hb_reg == 32'(HB_LIMIT));
    assign ts_count_o = ts_reg;
    assign seconds_o = sec_reg;
    assign dbus_o = dbus_reg;
    assign buf_byte_valid_o = bv_reg;
    assign buf_byte_o = byte_reg;
    assign buf_seg_o = seg_reg;
    assign buf_done_o = done_reg;
    assign buf_csum_ok_o = ok_reg;
endmodule : timing_event_stream_receiver

// file: sim/evstream_monitor.sv
// Purpose: Link checks for the event stream
// Assumes: One clock; K characters in either disparity
// Notes: Sees only the link characters
`timescale 1ns/1ns
module evstream_monitor (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [9:0] ev_char,
    input wire logic [9:0] dat_char
);
    logic c_ev, s_d, e_d, k_d;
    assign c_ev = ev_char inside {10'h0fa, 10'h305};
    assign s_d = dat_char inside {10'h0f4, 10'h30b};
    assign e_d = dat_char inside {10'h0f9, 10'h306};
    assign k_d = s_d || e_d || dat_char inside {10'h0fa, 10'h305};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_driven; $past(arst_n_i) |-> ev_char != 0 && dat_char != 0; endproperty
    a_driven: assert property (p_driven) else $error("link pair missing");
    property p_bal; $past(arst_n_i) |-> $countones(dat_char) inside {[4:6]}; endproperty
    a_bal: assert property (p_bal) else $error("data char unbalanced");
    property p_gap; c_ev |=> !c_ev [*3]; endproperty
    a_gap: assert property (p_gap) else $error("comma too soon");
    property p_ev_k; !(ev_char inside {10'h0f4, 10'h30b, 10'h0f9, 10'h306}); endproperty
    a_ev_k: assert property (p_ev_k) else $error("frame char in event slot");
    property p_dcomma; $past(arst_n_i) |-> !(dat_char inside {10'h0fa, 10'h305}); endproperty
    a_dcomma: assert property (p_dcomma) else $error("comma in data slot");
    property p_alt; k_d |=> !k_d; endproperty
    a_alt: assert property (p_alt) else $error("control char in dbus slot");
    property p_seg; s_d |=> !k_d ##1 !k_d; endproperty
    a_seg: assert property (p_seg) else $error("no address after start");
    property p_end; e_d |=> !k_d [*4]; endproperty
    a_end: assert property (p_end) else $error("no checksum after end");
    c_comma: cover property (c_ev);
    c_start: cover property (s_d);
    c_close: cover property (e_d);
endmodule : evstream_monitor

// file: sim/timing_event_stream_framer_tb.sv
// Purpose: Framer to receiver over the link, end to end
// Assumes: Receiver adds no delay
// Notes: Receiver outputs judge the stream
`timescale 1ns/1ns
module timing_event_stream_framer_tb;
    logic clk_i = 0, arst_n_i = 0, beacon_req_i = 0, log_restart_i = 0;
    logic buf_valid_i = 0, buf_last_i = 0, beacon_ack_o, buf_ready_o, buf_busy_o;
    logic locked_o, event_valid_o, beacon_o, presc_sync_o, log_stop_o, hb_timeout_o;
    logic buf_byte_valid_o, buf_done_o, buf_csum_ok_o;
    logic [3:0] src_req_i = 0, src_ack_o, meas_delay_i = 0, target_delay_i = 0;
    logic [3:0][7:0] src_code_i = 0;
    logic [7:0] dbus_i = 8'h5a, seg_addr_i = 8'ha0, buf_data_i = 0;
    logic [7:0] event_code_o, dbus_o, buf_byte_o, buf_seg_o, q[$], b[$];
    logic [31:0] ts_count_o, seconds_o;
    logic [7:0] u[4] = '{8'h01, 8'h6f, 8'h80, 8'hff};
    logic [7:0] sp[11] = '{8'h7b, 8'h7c, 8'h71, 8'h70, 8'h71, 8'h7d, 8'h7c, 8'h7f, 8'h79,
        8'h7a, 8'h22};
    logic [7:0] d[12] = '{8'hc0, 8'hff, 8'hee, 8'h99, 8'h01, 8'h80, 8'h7f, 8'hfe, 8'h10,
        8'h20, 8'h40, 8'h5a};
    int errors = 0, cmp_count = 0, bcn_n = 0, done_n = 0, ps_n = 0;
    evstream_if link ();
    timing_event_stream_framer timing_event_stream_framer_inst (.link(link.tx), .*);
    timing_event_stream_receiver #(.HB_LIMIT(50)) timing_event_stream_receiver_inst (
        .link(link.rx), .*);
    evstream_monitor evstream_monitor_inst (.clk_i, .arst_n_i, .ev_char(link.ev_char),
        .dat_char(link.dat_char));
    always #20 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        if (event_valid_o) q.push_back(event_code_o);
        if (buf_byte_valid_o) b.push_back(buf_byte_o);
        bcn_n += beacon_o;
        ps_n += presc_sync_o;
        done_n += buf_done_o;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task end_of_test;
        if (errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task bound(input int i);
        if (i >= 300) begin
            errors++;
            end_of_test();
        end
    endtask : bound
    task send(input logic [7:0] c);
        int i;
        @(negedge clk_i);
        beacon_req_i = c == evstream_pkg::EV_BEACON;
        src_req_i[0] = c != evstream_pkg::EV_BEACON;
        src_code_i[0] = c;
        for (i = 0; i < 300; i++) begin
            #1;
            if (beacon_ack_o || src_ack_o[0]) break;
            @(negedge clk_i);
        end
        bound(i);
        @(negedge clk_i);
        beacon_req_i = 0;
        src_req_i[0] = 0;
    endtask : send
    task wq(input int n);
        int i;
        for (i = 0; i < 300 && q.size() < n; i++) @(negedge clk_i);
        bound(i);
    endtask : wq
    task t_user;
        foreach (u[i]) begin
            send(u[i]);
            wq(1);
            chk("event_code", u[i], q.pop_front());
        end
    endtask : t_user
    task t_special;
        foreach (sp[i]) send(sp[i]);
        wq(10);
        chk("code_after_seq_end", 8'h22, q[9]);
        chk("ts_count", 1, ts_count_o);
        chk("seconds", 5, seconds_o);
        chk("log_stop", 1, log_stop_o);
        chk("beacons", 1, bcn_n);
        chk("presc", 1, ps_n);
    endtask : t_special
    task t_buf(input int n);
        int i, j, full;
        full = 0;
        done_n = 0;
        b.delete();
        @(negedge clk_i);
        buf_valid_i = 1;
        for (i = 0; i < n; i++) begin
            buf_data_i = d[i];
            buf_last_i = i == n - 1;
            for (j = 0; j < 300 && !buf_ready_o; j++) @(negedge clk_i);
            bound(j);
            full += j;
            @(negedge clk_i);
        end
        buf_valid_i = 0;
        buf_last_i = 0;
        for (j = 0; j < 300 && done_n == 0; j++) @(negedge clk_i);
        bound(j);
        // FIFO fills past 8 bytes
        chk("fifo_refused", n > 8, full > 0);
        chk("bytes", n, b.size());
        foreach (b[k]) chk("byte", d[k], b[k]);
        chk("segment", 8'ha0, buf_seg_o);
        chk("checksum", 1, buf_csum_ok_o);
    endtask : t_buf
    initial begin
        repeat (20) @(negedge clk_i);
        arst_n_i = 1;
        @(posedge clk_i);
        #1;
        chk("first_slot", 1, link.ev_char inside {10'h0fa, 10'h305});
        @(posedge clk_i);
        #1;
        chk("idle_data", 1, link.dat_char inside {10'h274, 10'h18b});
        chk("locked", 1, locked_o);
        t_user();
        t_special();
        chk("dbus", 8'h5a, dbus_o);
        t_buf(4);
        t_buf(12);
        chk("hb", 1, hb_timeout_o);
        end_of_test();
    end
endmodule : timing_event_stream_framer_tb
